// ==== verilog/sidrs_regs.v ====
// Chip identity, reset cause and interrupt protect-mode registers on APB
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "sidrs_defs.vh"
// What this block does
// RULE1 - A 5-bit version sits in bits 4..0, counting revisions 0 to 31.
// RULE2 - Bits 11..8 give program store size: none, 32K, 64K, 128K or 256K.
// RULE3 - Bits 15..12 give nonvolatile data size, zero meaning none.
// RULE4 - Bits 19..16 give volatile data size as 1K/2K/4K/8K one-hot codes.
// RULE5 - Bits 27..20 hold a two-digit BCD architecture code.
// RULE6 - Bits 30..28 give the program store type code.
// RULE7 - Bit 31 flags whether an extended identity word exists.
// RULE8 - Offset 0x04 reads a hardwired, reserved extension word.
// RULE9 - The reset cause field reads 0x6C after pin reset, 0x53 after dog.
// RULE10 - The protect register updates only with key 0x27A8 in bits 31..16.
// RULE11 - Bit 5 of the protect register selects protect mode, zero at reset.
// RULE12 - A watchdog overflow is recorded as the reset cause only when its reset enable is set.
// RULE13 - Bits 7..5 of the identity read 010; read-only writes are ignored.
module sidrs_regs #(
  parameter [4:0] VERSION = 5'h00,
  parameter [3:0] PSIZE = `SIDRS_PSIZE_NONE,
  parameter [3:0] NVDSIZE = `SIDRS_NVD_NONE,
  parameter [3:0] VDSIZE = `SIDRS_VD_NONE,
  parameter [7:0] ARCHITECTURE_BCD = 8'h00, // arbitrary value
  parameter [2:0] PTYPE = 3'h0, // arbitrary value
  parameter [0:0] EXTENSION_FLAG = 1'h0,
  parameter [31:0] EXID_VALUE = 32'h00000000 // arbitrary value
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire SRST,
  // Reset source qualifiers, sampled while SRST is high
  input wire WDOG_OVERFLOW,
  input wire WDOG_RESET_ENABLE,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Protect mode to the interrupt controller
  output reg IRQ_CTRL_PROTECT_ENABLE
);

  // Bus phase states
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ANSWER = 2'h1;

  // Identity word fields, named for what they report
  wire [4:0] version_field;
  wire [2:0] fixed_pattern;
  wire [3:0] program_store_size;
  wire [3:0] nv_data_store_size;
  wire [3:0] volatile_data_size;
  wire [7:0] architecture_code;
  wire [2:0] program_store_type;
  wire id_extension_flag;
  reg [31:0] id_word;

  // Bus phase tracking
  reg [1:0] state_reg;
  reg [1:0] state_next;
  wire setup;
  wire access;

  // Request decode
  wire is_write;
  wire is_read;
  wire addr_known;
  wire prot_slot;
  wire key_match;
  wire prot_write;

  // Reset cause
  reg [7:0] cause_reg;
  reg [7:0] cause_next;
  wire dog_cause;

  // Next values of the outputs
  reg prot_next;
  reg [31:0] rdata_next;
  reg err_next;
  reg ready_next;

  // Word-aligned known address check
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SIDRS_OFF_ID) || (a == `SIDRS_OFF_EXID) ||
        (a == `SIDRS_OFF_CAUSE) || (a == `SIDRS_OFF_RSVD_A) ||
        (a == `SIDRS_OFF_RSVD_B) || (a == `SIDRS_OFF_PROT);
    end
  endfunction

  // Protect register address match
  function prot_addr;
    input [7:0] a;
    begin
      prot_addr = (a == `SIDRS_OFF_PROT);
    end
  endfunction

  // Key match in the upper half of a write word
  function key_ok;
    input [31:0] d;
    begin
      key_ok = (d[`SIDRS_PROT_KEY_HI:`SIDRS_PROT_KEY_LO] == `SIDRS_PROT_KEY);
    end
  endfunction

  // Protect register image; key field reads zero
  function [31:0] prot_image;
    input bit_value;
    begin
      prot_image = `SIDRS_WORD_ZERO;
      prot_image[`SIDRS_PROT_BIT] = bit_value;
    end
  endfunction

  // Cause code; watchdog only with its reset enabled
  function [7:0] cause_code;
    input from_dog;
    begin
      if (from_dog) begin
        cause_code = `SIDRS_CAUSE_WDOG; // see RULE9
      end else begin
        cause_code = `SIDRS_CAUSE_PIN; // see RULE9
      end
    end
  endfunction

  // Hardwired identity fields
  assign version_field = VERSION; // see RULE1
  assign fixed_pattern = `SIDRS_FIXED_765; // see RULE13
  assign program_store_size = PSIZE; // see RULE2
  assign nv_data_store_size = NVDSIZE; // see RULE3
  assign volatile_data_size = VDSIZE; // see RULE4
  assign architecture_code = ARCHITECTURE_BCD; // see RULE5
  assign program_store_type = PTYPE; // see RULE6
  assign id_extension_flag = EXTENSION_FLAG; // see RULE7

  // Identity word assembled field by field
  always @* begin
    id_word = `SIDRS_WORD_ZERO;
    id_word[`SIDRS_VER_HI:`SIDRS_VER_LO] = version_field; // see RULE1
    id_word[`SIDRS_FIX_HI:`SIDRS_FIX_LO] = fixed_pattern; // see RULE13
    id_word[`SIDRS_PSZ_HI:`SIDRS_PSZ_LO] = program_store_size; // see RULE2
    id_word[`SIDRS_NVD_HI:`SIDRS_NVD_LO] = nv_data_store_size; // see RULE3
    id_word[`SIDRS_VD_HI:`SIDRS_VD_LO] = volatile_data_size; // see RULE4
    id_word[`SIDRS_AC_HI:`SIDRS_AC_LO] = architecture_code; // see RULE5
    id_word[`SIDRS_PTY_HI:`SIDRS_PTY_LO] = program_store_type; // see RULE6
    id_word[`SIDRS_XF_BIT] = id_extension_flag; // see RULE7
  end

  // Setup and access phases of the current transfer
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & (state_reg == S_ANSWER);

  // Request qualifiers and address decode
  assign is_write = access & PWRITE;
  assign is_read = setup & ~PWRITE;
  assign addr_known = mapped(PADDR);
  assign prot_slot = prot_addr(PADDR);
  assign key_match = key_ok(PWDATA);
  assign prot_write = is_write & prot_slot & key_match; // see RULE10

  // Answer state follows each setup for one cycle
  always @* begin
    state_next = S_IDLE;
    case (state_reg)
      S_IDLE: begin
        if (setup) begin
          state_next = S_ANSWER;
        end
      end
      S_ANSWER: begin
        if (setup) begin
          state_next = S_ANSWER;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Zero wait states: ready in the cycle after setup
  always @* begin
    ready_next = 1'h0;
    if (state_next == S_ANSWER) begin
      ready_next = 1'h1;
    end
  end

  // Watchdog cause needs its reset enable
  assign dog_cause = WDOG_OVERFLOW & WDOG_RESET_ENABLE; // see RULE12

  // Cause picked at every edge that sees reset
  always @* begin
    cause_next = cause_reg;
    if (SRST) begin
      cause_next = cause_code(dog_cause); // see RULE9
    end
  end

  // Keyed protect bit update; every other write is dropped
  always @* begin
    prot_next = IRQ_CTRL_PROTECT_ENABLE; // see RULE13
    if (prot_write) begin
      prot_next = PWDATA[`SIDRS_PROT_BIT]; // see RULE11
    end
  end

  // Error answer for offsets outside the map
  always @* begin
    err_next = 1'h0;
    if (setup && !addr_known) begin
      err_next = 1'h1;
    end
  end

  // Read data of the addressed slot
  always @* begin
    rdata_next = `SIDRS_WORD_ZERO;
    if (is_read && addr_known) begin
      case (PADDR)
        `SIDRS_OFF_ID: begin
          rdata_next = id_word;
        end
        `SIDRS_OFF_EXID: begin
          rdata_next = EXID_VALUE; // see RULE8
        end
        `SIDRS_OFF_CAUSE: begin
          rdata_next[`SIDRS_RC_HI:`SIDRS_RC_LO] = cause_reg; // see RULE9
        end
        // Reserved slots read zero
        `SIDRS_OFF_RSVD_A: begin
          rdata_next = `SIDRS_WORD_ZERO;
        end
        `SIDRS_OFF_RSVD_B: begin
          rdata_next = `SIDRS_WORD_ZERO;
        end
        `SIDRS_OFF_PROT: begin
          rdata_next = prot_image(IRQ_CTRL_PROTECT_ENABLE); // see RULE10
        end
        default: begin
          rdata_next = `SIDRS_WORD_ZERO;
        end
      endcase
    end
  end

  // Bus phase register
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset cause register, loaded only while reset is seen
  always @(posedge CORE_CLK) begin
    cause_reg <= cause_next;
  end

  // Protect mode bit, cleared by reset
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      IRQ_CTRL_PROTECT_ENABLE <= `SIDRS_PROT_RESET; // see RULE11
    end else begin
      IRQ_CTRL_PROTECT_ENABLE <= prot_next;
    end
  end

  // Ready pulse for the access cycle
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      PREADY <= 1'h0;
    end else begin
      PREADY <= ready_next;
    end
  end

  // Error flag, valid with ready
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      PSLVERR <= 1'h0;
    end else begin
      PSLVERR <= err_next;
    end
  end

  // Read data taken at setup, held until the next one
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      PRDATA <= `SIDRS_WORD_ZERO;
    end else if (setup) begin
      PRDATA <= rdata_next;
    end
  end

endmodule

// ==== verilog/sidrs_defs.vh ====
// Register map, field layout and constants of the identity/reset bank
`ifndef SIDRS_DEFS_VH
`define SIDRS_DEFS_VH

// Byte offsets
`define SIDRS_OFF_ID 8'h00
`define SIDRS_OFF_EXID 8'h04
`define SIDRS_OFF_CAUSE 8'h08
`define SIDRS_OFF_RSVD_A 8'h10
`define SIDRS_OFF_RSVD_B 8'h14
`define SIDRS_OFF_PROT 8'h18

// Identification word field codes
`define SIDRS_FIXED_765 3'h2
`define SIDRS_PSIZE_NONE 4'h0
`define SIDRS_PSIZE_32K 4'h3
`define SIDRS_PSIZE_64K 4'h5
`define SIDRS_PSIZE_128K 4'h7
`define SIDRS_PSIZE_256K 4'h8
`define SIDRS_NVD_NONE 4'h0
`define SIDRS_VD_NONE 4'h0
`define SIDRS_VD_1K 4'h1
`define SIDRS_VD_2K 4'h2
`define SIDRS_VD_4K 4'h4
`define SIDRS_VD_8K 4'h8
`define SIDRS_VERSION_MAX 5'h1F

// Reset cause codes
`define SIDRS_CAUSE_PIN 8'h6C
`define SIDRS_CAUSE_WDOG 8'h53

// Protect register layout
`define SIDRS_PROT_KEY 16'h27A8
`define SIDRS_PROT_KEY_HI 31
`define SIDRS_PROT_KEY_LO 16
`define SIDRS_PROT_BIT 5
`define SIDRS_PROT_RESET 1'h0

// Identity word field positions
`define SIDRS_VER_HI 4
`define SIDRS_VER_LO 0
`define SIDRS_FIX_HI 7
`define SIDRS_FIX_LO 5
`define SIDRS_PSZ_HI 11
`define SIDRS_PSZ_LO 8
`define SIDRS_NVD_HI 15
`define SIDRS_NVD_LO 12
`define SIDRS_VD_HI 19
`define SIDRS_VD_LO 16
`define SIDRS_AC_HI 27
`define SIDRS_AC_LO 20
`define SIDRS_PTY_HI 30
`define SIDRS_PTY_LO 28
`define SIDRS_XF_BIT 31

// Reset cause field position
`define SIDRS_RC_HI 7
`define SIDRS_RC_LO 0

// Whole-word zero for idle and cleared data
`define SIDRS_WORD_ZERO 32'h00000000

`endif

// ==== verification/sidrs_props_properties.sv ====
// Concurrent checks on the identity and reset bank ports
`timescale 1ns/1ps
module sidrs_props (
  input wire CORE_CLK, SRST, WDOG_OVERFLOW, WDOG_RESET_ENABLE,
  input wire PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire IRQ_CTRL_PROTECT_ENABLE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA, PRDATA
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  reg [7:0] cause_reg;
  wire rd = PREADY && !PWRITE;
  wire wp = PREADY && PWRITE && PADDR == 8'h18;
  wire key_ok = PWDATA[31:16] == 16'h27A8;
  // Expected cause, taken at each reset edge
  always @(posedge CORE_CLK) begin
    if (SRST)
      cause_reg <= (WDOG_OVERFLOW && WDOG_RESET_ENABLE) ? 8'h53 : 8'h6C;
  end
  property p_id; rd && PADDR == 8'h00 |-> PRDATA == 32'h40; endproperty
  a_id: assert property (p_id) else $error("bad id");
  property p_fix; rd && PADDR == 8'h00 |-> PRDATA[7:5] == 3'h2; endproperty
  a_fix: assert property (p_fix) else $error("bad id bits");
  property p_exid; rd && PADDR == 8'h04 |-> PRDATA == 32'h0; endproperty
  a_exid: assert property (p_exid) else $error("bad ext");
  property p_cause; rd && PADDR == 8'h08 |-> PRDATA == cause_reg; endproperty
  a_cause: assert property (p_cause) else $error("bad cause");
  property p_key; rd && PADDR == 8'h18 |-> PRDATA[31:16] == 0; endproperty
  a_key: assert property (p_key) else $error("key seen");
  property p_bad; wp && !key_ok |=> $stable(IRQ_CTRL_PROTECT_ENABLE);
  endproperty
  a_bad: assert property (p_bad) else $error("bad key took");
  property p_good;
    wp && key_ok |=> IRQ_CTRL_PROTECT_ENABLE == $past(PWDATA[5]);
  endproperty
  a_good: assert property (p_good) else $error("no update");
  property p_rst;
    disable iff (1'b0) SRST |=> !IRQ_CTRL_PROTECT_ENABLE && !PREADY;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_good: cover property (wp && key_ok);
  c_wdog: cover property (rd && PADDR == 8'h08 && PRDATA == 32'h53);
  c_err: cover property (PREADY && PSLVERR);
endmodule
bind sidrs_regs sidrs_props chk (
  .CORE_CLK(CORE_CLK),
  .SRST(SRST),
  .WDOG_OVERFLOW(WDOG_OVERFLOW),
  .WDOG_RESET_ENABLE(WDOG_RESET_ENABLE),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .IRQ_CTRL_PROTECT_ENABLE(IRQ_CTRL_PROTECT_ENABLE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PRDATA(PRDATA)
);

// ==== verification/testbench.sv ====
// Random register traffic bench for the identity and reset bank
`timescale 1ns/1ps
module testbench;
  reg CORE_CLK = 0, SRST = 1, WDOG_OVERFLOW = 0, WDOG_RESET_ENABLE = 0;
  reg PSEL = 0, PENABLE = 0, PWRITE = 0, w, e, prot;
  reg [7:0] PADDR = 0, a, cause;
  reg [31:0] PWDATA = 0, d, wd;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, IRQ_CTRL_PROTECT_ENABLE;
  integer fails = 0, samples_checked = 0, i, j;
  sidrs_regs dut (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST),
    .WDOG_OVERFLOW(WDOG_OVERFLOW),
    .WDOG_RESET_ENABLE(WDOG_RESET_ENABLE),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .IRQ_CTRL_PROTECT_ENABLE(IRQ_CTRL_PROTECT_ENABLE)
  );
  initial forever #2 CORE_CLK = ~CORE_CLK;
  // Compare and count
  task check(input string nm, input [31:0] seen, exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, held until PREADY
  task apb(input wr, input [7:0] ad, input [31:0] wdat);
    @(posedge CORE_CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= wdat;
    @(posedge CORE_CLK) PENABLE <= 1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    d = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // Expected read data
  function [31:0] exp_rd(input [7:0] ad);
    case (ad)
      8'h00: exp_rd = 32'h40;
      8'h08: exp_rd = {24'h0, cause};
      8'h18: exp_rd = {26'h0, prot, 5'h0};
      default: exp_rd = 32'h0;
    endcase
  endfunction
  task wrap_up;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000 fails = fails + 1;
    wrap_up;
  end
  // Resets of each cause, then random traffic
  initial begin
    i = $urandom(32'h579d);
    for (j = 0; j < 4; j = j + 1) begin
      if (j != 0) @(posedge CORE_CLK);
      SRST <= 1;
      {WDOG_RESET_ENABLE, WDOG_OVERFLOW} <= j[1:0];
      repeat (4) @(posedge CORE_CLK);
      SRST <= 0;
      cause = (j == 3) ? 8'h53 : 8'h6C;
      prot = 0;
      for (i = 0; i < 60; i = i + 1) begin
        a = (i == 0) ? 8'h19 : 8'($urandom_range(8) << 2);
        w = $urandom;
        wd = $urandom;
        if ($urandom_range(1)) wd[31:16] = 16'h27A8;
        // Fixed corners: cause read, then a keyed protect write
        if (i == 1) begin
          a = 8'h08;
          w = 1'h0;
        end
        if (i == 2) begin
          a = 8'h18;
          w = 1'h1;
          wd = 32'h27A80020;
        end
        apb(w, a, wd);
        if (!w) check("rdata", d, exp_rd(a));
        check("err", e, a[1:0] != 0 || a == 8'h0C || a > 8'h18);
        if (w && a == 8'h18 && wd[31:16] == 16'h27A8) prot = wd[5];
        @(negedge CORE_CLK) check("prot", IRQ_CTRL_PROTECT_ENABLE, prot);
      end
    end
    wrap_up;
  end
endmodule
